/* logic/evirq_unit.sv */
// Event interrupt pulse unit: latching, class select, pulse timing.
`timescale 1ns/1ps
module evirq_unit (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire evirq_pkg::evirq_mode_t mode,
    input wire logic stop_cmd,
    input wire logic class_global,
    input wire logic bus_timeout_irq_mask,
    input wire logic [evirq_pkg::WAKE_W-1:0] wake_en_first,
    input wire logic [evirq_pkg::WAKE_W-1:0] wake_en_second,
    input wire logic [evirq_pkg::FAIL_W-1:0] fail_irq_capable,
    input wire evirq_pkg::evirq_evt_t evt,
    input wire evirq_pkg::evirq_clr_t clr,
    input wire logic evt_pin_i,
    output logic evt_pin_o,
    output logic evt_pin_oe,
    output logic [evirq_pkg::WAKE_W-1:0] wake_status_first,
    output logic [evirq_pkg::WAKE_W-1:0] wake_status_second,
    output logic bus_timeout_flag,
    output logic [evirq_pkg::FAIL_W-1:0] fail_status,
    output logic hw_config,
    output logic hw_config_valid
);
    import evirq_pkg::*;

    // ==========================================================
    // Event latches
    // ==========================================================
    // Sticky bits: a set in the same cycle as its clear wins.
    // Wake bits are only captured when that source is enabled.
    logic [WAKE_W-1:0] wk1_q;
    logic [WAKE_W-1:0] wk2_q;
    logic bus_timeout_flag_q;
    logic [FAIL_W-1:0] fl_q;
    logic [WAKE_W-1:0] wk1_set;
    logic [WAKE_W-1:0] wk2_set;
    logic bus_timeout_flag_set;
    logic [FAIL_W-1:0] fl_set;

    assign wk1_set = evt.wake_first & wake_en_first;
    assign wk2_set = evt.wake_second & wake_en_second;
    assign bus_timeout_flag_set = evt.bus_timeout_flag;
    // Restart and fail-safe causes are strapped off in fail_irq_capable.
    assign fl_set = evt.fail & fail_irq_capable;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wk1_q <= '0;
            wk2_q <= '0;
            bus_timeout_flag_q <= 1'b0;
            fl_q <= '0;
        end else if (clk_en) begin
            wk1_q <= (wk1_q & ~clr.wake_first) | wk1_set;
            wk2_q <= (wk2_q & ~clr.wake_second) | wk2_set;
            bus_timeout_flag_q <= (bus_timeout_flag_q & ~clr.bus_timeout_flag) | bus_timeout_flag_set;
            fl_q <= (fl_q & ~clr.fail) | fl_set;
        end
    end

    // ==========================================================
    // Interrupt qualification
    // ==========================================================
    logic wake_trig;
    logic fail_trig;
    logic bus_timeout_flag_trig;
    logic stop_trig;
    logic trig;
    logic any_wake;
    logic active_mode;

    assign any_wake = |wk1_q || |wk2_q;
    assign active_mode = (mode == EVIRQ_MODE_NORMAL) ||
                         (mode == EVIRQ_MODE_STOP);
    assign wake_trig = |wk1_set || |wk2_set;
    // The timeout flag ignores the class bit; only its mask counts.
    assign bus_timeout_flag_trig = bus_timeout_flag_set && !bus_timeout_irq_mask;
    assign fail_trig = class_global && |fl_set;
    assign stop_trig = stop_cmd && any_wake;
    assign trig = wake_trig || bus_timeout_flag_trig || fail_trig || stop_trig;

    // ==========================================================
    // Pulse sequencer
    // ==========================================================
    // Mode is only an input here, nothing is fed back to it.
    evirq_state_t st_q;
    logic [CNT_W-1:0] cnt_q;
    logic pend_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pend_q <= 1'b0;
        end else if (clk_en) begin
            if (trig && active_mode && !(st_q == EVIRQ_IDLE)) begin
                pend_q <= 1'b1;
            end else if (st_q == EVIRQ_IDLE) begin
                pend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_q <= EVIRQ_IDLE;
            cnt_q <= '0;
        end else if (clk_en) begin
            case (st_q)
                EVIRQ_IDLE: begin
                    if (active_mode && (trig || pend_q)) begin
                        st_q <= EVIRQ_PULSE;
                        cnt_q <= CNT_W'(PULSE_CYC - 1);
                    end
                end
                EVIRQ_PULSE: begin
                    if (cnt_q == '0) begin
                        st_q <= EVIRQ_GAP;
                        cnt_q <= CNT_W'(GAP_CYC - 1);
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                EVIRQ_GAP: begin
                    if (cnt_q == '0) begin
                        st_q <= EVIRQ_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: begin
                    st_q <= EVIRQ_IDLE;
                    cnt_q <= '0;
                end
            endcase
        end
    end

    // ==========================================================
    // Pin driver and status snapshot
    // ==========================================================
    logic fall;
    assign fall = (st_q == EVIRQ_IDLE) && active_mode && (trig || pend_q);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            evt_pin_o <= 1'b1;
            evt_pin_oe <= 1'b0;
        end else if (clk_en) begin
            evt_pin_oe <= (mode != EVIRQ_MODE_INIT);
            if (fall) begin
                evt_pin_o <= 1'b0;
            end else if (st_q == EVIRQ_PULSE && cnt_q == '0) begin
                evt_pin_o <= 1'b1;
            end
        end
    end

    // The host sees the latches as they stood at each falling edge.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wake_status_first <= '0;
            wake_status_second <= '0;
            bus_timeout_flag <= 1'b0;
            fail_status <= '0;
        end else if (clk_en && fall) begin
            wake_status_first <= wk1_q | wk1_set;
            wake_status_second <= wk2_q | wk2_set;
            bus_timeout_flag <= bus_timeout_flag_q | bus_timeout_flag_set;
            fail_status <= fl_q | fl_set;
        end
    end

    // ==========================================================
    // Configuration select sampling
    // ==========================================================
    // Pin is asynchronous, so it passes two flops before filtering.
    logic pin_s1_q;
    logic pin_s2_q;
    logic flt_lvl_q;
    logic [CNT_W-1:0] flt_cnt_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
        end else if (clk_en) begin
            pin_s1_q <= evt_pin_i;
            pin_s2_q <= pin_s1_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            flt_lvl_q <= 1'b0;
            flt_cnt_q <= '0;
            hw_config <= 1'b0;
            hw_config_valid <= 1'b0;
        end else if (clk_en && mode == EVIRQ_MODE_INIT) begin
            if (pin_s2_q != flt_lvl_q) begin
                flt_lvl_q <= pin_s2_q;
                flt_cnt_q <= '0;
            end else if (flt_cnt_q == CNT_W'(CFG_FLT_CYC - 1)) begin
                hw_config <= flt_lvl_q;
                hw_config_valid <= 1'b1;
            end else begin
                flt_cnt_q <= flt_cnt_q + 1'b1;
            end
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    a_pulse_width_held: assert property (@(posedge clk) disable iff (!resetn)
        ($fell(evt_pin_o) && clk_en) |-> (st_q == EVIRQ_PULSE &&
        cnt_q == CNT_W'(PULSE_CYC - 1)))
        else $error("pulse started with wrong count");
    a_gap_before_pulse: assert property (@(posedge clk) disable iff (!resetn)
        (st_q == EVIRQ_GAP) |-> !fall)
        else $error("pulse started inside the gap");
    a_idle_high: assert property (@(posedge clk) disable iff (!resetn)
        (st_q == EVIRQ_GAP || (st_q == EVIRQ_IDLE && !fall)) |=>
        evt_pin_o)
        else $error("pin low outside a pulse");
    a_no_fail_class0: assert property (@(posedge clk) disable iff (!resetn)
        (clk_en && st_q == EVIRQ_IDLE && !class_global && !pend_q &&
        !wake_trig && !bus_timeout_flag_trig && !stop_trig) |-> !fall)
        else $error("class 0 pulse without wake cause");
    a_mask_blocks_to: assert property (@(posedge clk) disable iff (!resetn)
        bus_timeout_irq_mask |-> !bus_timeout_flag_trig)
        else $error("masked timeout raised an interrupt");
    a_stop_pulses: assert property (@(posedge clk) disable iff (!resetn)
        (clk_en && stop_cmd && any_wake && active_mode &&
        st_q == EVIRQ_IDLE) |=> !evt_pin_o)
        else $error("stop entry with wake bits did not pulse");
    a_latch_holds: assert property (@(posedge clk) disable iff (!resetn)
        (clk_en && |wk1_q && ~|clr.wake_first) |=> |wk1_q)
        else $error("wake latch lost without a clear");
    a_defer_kept: assert property (@(posedge clk) disable iff (!resetn)
        (pend_q && st_q == EVIRQ_GAP && cnt_q == '0 && clk_en &&
        active_mode) |=> ##1 !evt_pin_o)
        else $error("deferred pulse was dropped");
    a_init_no_drive: assert property (@(posedge clk) disable iff (!resetn)
        (clk_en && mode == EVIRQ_MODE_INIT) |=> !evt_pin_oe)
        else $error("pin driven during init mode");
endmodule : evirq_unit

/* logic/evirq_pkg.sv */
// Constants and carrier types for the event interrupt pulse unit.
// What this block does
// - Pulse event output low for 100 us.
// - Keep output high 100 us between pulses.
// - Push/pull drive, high when idle.
// - Interrupts never change operating mode.
// - Class 0 default: wake status events only.
// - Wake events interrupt only if source enabled.
// - Bus timeout is wake; mask overrides class.
// - Class 1 adds failures, never pin levels.
// - No interrupt for restart or fail-safe faults.
// - Stop entry with wake bits set pulses.
// - Status registers update at pulse falling edge.
// - Events latch until host clears them.
// - Init mode samples pin for configuration.
// - Config level filtered 10 us before accepted.
package evirq_pkg;
    localparam int CLK_MHZ = 250;
    localparam int PULSE_US = 100;
    localparam int GAP_US = 100;
    localparam int CFG_FLT_US = 10;
    localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
    localparam int GAP_CYC = GAP_US * CLK_MHZ;
    localparam int CFG_FLT_CYC = CFG_FLT_US * CLK_MHZ;
    localparam int WAKE_W = 8;
    localparam int FAIL_W = 16;
    localparam int CNT_W = 16;
    localparam logic RST_CLASS = 1'b0;

    typedef enum logic [1:0] {
        EVIRQ_MODE_INIT = 2'b00,
        EVIRQ_MODE_NORMAL = 2'b01,
        EVIRQ_MODE_STOP = 2'b10,
        EVIRQ_MODE_OTHER = 2'b11
    } evirq_mode_t;

    typedef enum logic [1:0] {
        EVIRQ_IDLE = 2'b00,
        EVIRQ_PULSE = 2'b01,
        EVIRQ_GAP = 2'b10
    } evirq_state_t;

    // Event inputs, one cycle pulses from the status logic.
    typedef struct packed {
        logic [WAKE_W-1:0] wake_first;
        logic [WAKE_W-1:0] wake_second;
        logic bus_timeout_flag;
        logic [FAIL_W-1:0] fail;
    } evirq_evt_t;

    // Per-bit clear strobes from the SPI read-and-clear path.
    typedef struct packed {
        logic [WAKE_W-1:0] wake_first;
        logic [WAKE_W-1:0] wake_second;
        logic bus_timeout_flag;
        logic [FAIL_W-1:0] fail;
    } evirq_clr_t;
endpackage : evirq_pkg

/* verification/evirq_host.sv */
// Host side model: resolves the event wire and reads and clears failures.
`timescale 1ns/1ps
module evirq_host (
    input wire logic clk,
    input wire logic cfg_level,
    input wire logic evt_pin_o,
    input wire logic evt_pin_oe,
    input wire logic [evirq_pkg::FAIL_W-1:0] fail_status,
    output logic evt_pin_i,
    output evirq_pkg::evirq_clr_t clr
);
    import evirq_pkg::*;
    logic pin_q;
    evirq_clr_t clr_d;
    // The strap only wins while the device is not driving the wire.
    assign evt_pin_i = evt_pin_oe ? evt_pin_o : cfg_level;
    initial begin
        clr = '0;
        pin_q = 1'b1;
    end
    // Failures are read at each pulse and cleared; wake bits are kept.
    // One assignment per edge, so the strobe never glitches in a step.
    always @(negedge clk) begin
        clr_d = '0;
        if (pin_q && !evt_pin_o && evt_pin_oe) begin
            clr_d.fail = fail_status;
        end
        clr <= clr_d;
        pin_q <= evt_pin_o;
    end
endmodule : evirq_host

/* verification/event_interrupt_pulse_unit_tb.sv */
// Testbench for the event interrupt pulse unit.
`timescale 1ns/1ps
module event_interrupt_pulse_unit_tb;
    import evirq_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    evirq_mode_t mode = EVIRQ_MODE_INIT;
    logic stop_cmd = 1'b0;
    logic class_global = 1'b0;
    logic cfg_level = 1'b1;
    evirq_evt_t evt = '0;
    evirq_clr_t clr;
    logic pin_i, pin_o, pin_oe, to_flag, hw_cfg, hw_cfg_valid;
    logic [WAKE_W-1:0] st_first, st_second;
    logic [FAIL_W-1:0] st_fail;
    int fail_count = 0;
    int n_checks = 0;
    int n;

    always #2 clk = ~clk;

    evirq_unit evirq_unit_inst (
        .clk(clk), .resetn(resetn), .clk_en(1'b1), .mode(mode),
        .stop_cmd(stop_cmd), .class_global(class_global),
        .bus_timeout_irq_mask(1'b1), .wake_en_first(8'h01),
        .wake_en_second(8'h00), .fail_irq_capable(16'h00ff),
        .evt(evt), .clr(clr), .evt_pin_i(pin_i), .evt_pin_o(pin_o),
        .evt_pin_oe(pin_oe), .wake_status_first(st_first),
        .wake_status_second(st_second), .bus_timeout_flag(to_flag),
        .fail_status(st_fail), .hw_config(hw_cfg),
        .hw_config_valid(hw_cfg_valid));

    evirq_host evirq_host_inst (
        .clk(clk), .cfg_level(cfg_level), .evt_pin_o(pin_o),
        .evt_pin_oe(pin_oe), .fail_status(st_fail),
        .evt_pin_i(pin_i), .clr(clr));

    // ================================================================
    // Shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time,
                got, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    // Counts falling edges until the pin shows val; a hang ends the run.
    task automatic wait_pin(input logic val);
        n = 0;
        while (pin_o !== val) begin
            n++;
            if (n > 30000) begin
                fail_count++;
                end_sim();
            end
            @(negedge clk);
        end
    endtask : wait_pin

    task automatic send(input evirq_evt_t e, input logic stop);
        evt = e;
        stop_cmd = stop;
        @(negedge clk);
        evt = '0;
        stop_cmd = 1'b0;
    endtask : send

    function automatic evirq_evt_t mk(input logic [7:0] wf,
        input logic [7:0] ws, input logic to, input logic [15:0] f);
        return '{wf, ws, to, f};
    endfunction : mk

    task automatic quiet(input evirq_evt_t e);
        send(e, 1'b0);
        repeat (20) begin
            @(negedge clk);
            check(pin_o, 1'b1);
        end
    endtask : quiet

    // ================================================================
    // Scenarios
    task automatic s_config();
        check(pin_oe, 1'b0);
        repeat (2380) @(negedge clk);
        check(hw_cfg_valid, 1'b0);
        repeat (220) @(negedge clk);
        check({hw_cfg, hw_cfg_valid}, 2'b11);
    endtask : s_config

    task automatic s_refuse();
        mode = EVIRQ_MODE_NORMAL;
        repeat (2) @(negedge clk);
        check({pin_oe, pin_o}, 2'b11);
        quiet(mk(8'h02, 8'h00, 1'b0, 16'h0000));
        quiet(mk(8'h00, 8'h01, 1'b0, 16'h0000));
        quiet(mk(8'h00, 8'h00, 1'b1, 16'h0000));
        quiet(mk(8'h00, 8'h00, 1'b0, 16'h0001));
        quiet(mk(8'h00, 8'h00, 1'b0, 16'h0100));
        check(st_first, 8'h00);
    endtask : s_refuse

    // The stop entry lands in the gap, so its pulse must be held back.
    task automatic s_pulse();
        send(mk(8'h01, 8'h00, 1'b0, 16'h0000), 1'b0);
        check(pin_o, 1'b0);
        check({st_first, st_fail}, 24'h010001);
        check({to_flag, st_second}, 9'h100);
        wait_pin(1'b1);
        check(n, 32'd25000);
        fork
            wait_pin(1'b0);
            begin
                repeat (100) @(negedge clk);
                class_global = 1'b1;
                mode = EVIRQ_MODE_STOP;
                send(mk(8'h00, 8'h00, 1'b0, 16'h0002), 1'b1);
            end
        join
        // The sequencer spends one idle cycle before the deferred pulse.
        check(n, 32'd25001);
        check(st_first, 8'h01);
        check(st_fail, 16'h0002);
        check(pin_oe, 1'b1);
    endtask : s_pulse

    initial begin
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        s_config();
        s_refuse();
        s_pulse();
        end_sim();
    end
endmodule : event_interrupt_pulse_unit_tb
